//--- shared/timer_consts.vh
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH
// word offsets (byte addresses = 4 * index)
`define REG_SRC01      4'h0
`define REG_SRC23      4'h1
`define REG_SRC4       4'h2
`define REG_CTRL       4'h3
`define REG_RELOAD     4'h4
`define REG_COUNT      4'h5
`define REG_STATUS     4'h6
`define REG_MASK       4'h7
// control register fields
`define CTRL_START     0
`define CTRL_GATE_LO   1
`define CTRL_GATE_HI   2
`define CTRL_PULSE_EN  3
`define CTRL_PULSE_INV 4
`define CTRL_PCLK      5
`define CTRL_LSRC_LO   6
`define CTRL_LSRC_HI   7
`define CTRL_W         8
`define CTRL_RESET     8'h00
// gate modes
`define GATE_OFF       2'h0
`define GATE_LOW       2'h1
`define GATE_HIGH      2'h2
// source codes
`define SRC_FAST       3'h0
`define SRC_DIV8       3'h1
`define SRC_DIV32      3'h2
`define SRC_DIV64      3'h3
`define SRC_SLOW       3'h5
`define SRC_SUB        3'h6
`define LSRC_FAST      2'h0
`define LSRC_DIV8      2'h1
`define LSRC_DIV32     2'h2
`define LSRC_SUB       2'h3
// prescaler divide terminal counts (minus one)
`define DIV2_TC        6'h01
`define DIV8_TC        6'h07
`define DIV32_TC       6'h1f
`define DIV64_TC       6'h3f
`define SRC_FIELD_W    4
`define SRC_RESET      8'h00
`endif

//--- rtl/gated_reload_down_timer.v
`timescale 1ns/10ps
// What this block does
// R1: with start set and the gate active, the counter drops by one per tick.
// R2: in high-active gate mode a low gate freezes the counter value.
// R3: an underflow reloads the counter from the reload register.
// R4: every underflow sets the timer interrupt request bit.
// R5: clearing start halts the counter at its present value.
// R6: the gate source holds each level for two or more source periods.
// R7: gate mode is off, count-while-low or count-while-high.
// R8: an optional pulse output with selectable polarity.
// R9: with option bit 0 the two legacy bits pick fast, /8, /32 or sub clock.
// R10: with option bit 1 a three-bit field adds /64 and the slow oscillator.
// R11: software never writes extended codes 100 or 111.
// R12: the fast source is the timer clock undivided or divided by two.
// R13: source registers hold two four-bit fields; the third serves timer 4.
// R14: unused bits of the timer-4 source register read 0, write 0.
// R15: the gate is synchronised and sampled only on count-source ticks.
`include "timer_consts.vh"
module gated_reload_down_timer #(
    parameter CNT_W    = 16,
    parameter TIMER_ID = 0
) (
    // clock and reset
    input  wire              clock_i,
    input  wire              resetn_i,
    input  wire              enable_i,
    // avalon-mm slave
    input  wire [3:0]        address_i,
    input  wire              read_i,
    input  wire              write_i,
    input  wire [31:0]       writedata_i,
    output reg  [31:0]       readdata_o,
    output wire              waitrequest_o,
    // count-source ticks from outside
    input  wire              slow_osc_tick_i,
    input  wire              sub_clock_32k_tick_i,
    // pins
    input  wire              gate_input_pin_i,
    output wire              pulse_o,
    output wire              irq_o
);

    reg  [7:0]       src01_q;
    reg  [7:0]       src23_q;
    reg  [3:0]       src4_q;
    reg  [7:0]       ctrl_q;
    reg  [CNT_W-1:0] reload_q;
    reg  [CNT_W-1:0] count_q;
    reg              status_q;
    reg              mask_q;
    reg              ack_q;
    reg  [5:0]       pre_q;
    reg  [2:0]       gate_sync_q;
    reg              gate_lvl_q;
    reg              toggle_q;

    // one wait state: request answered on the cycle after it is seen
    wire             access = (read_i | write_i) & enable_i;
    wire             wr_en  = write_i & ack_q & enable_i;
    // enable low keeps waitrequest up, so a stalled request is never lost
    assign waitrequest_o = (read_i | write_i) & ~(ack_q & enable_i);

    // field of this timer within its source register
    function [3:0] pick_field;
        input integer id;
        input [7:0]   s01;
        input [7:0]   s23;
        input [3:0]   s4;
        begin
            if (id == 0)
                pick_field = s01[3:0];
            else if (id == 1)
                pick_field = s01[7:4];
            else if (id == 2)
                pick_field = s23[3:0];
            else if (id == 3)
                pick_field = s23[7:4];
            else
                pick_field = s4;
        end
    endfunction

    wire [3:0] my_src = pick_field(TIMER_ID, src01_q, src23_q, src4_q); // see R13

    // prescaler ticks
    wire div2_t  = (pre_q[0] == `DIV2_TC);
    wire div8_t  = (pre_q[2:0] == `DIV8_TC);
    wire div32_t = (pre_q[4:0] == `DIV32_TC);
    wire div64_t = (pre_q == `DIV64_TC);
    wire fast_t  = ctrl_q[`CTRL_PCLK] ? 1'b1 : div2_t; // see R12

    reg  tick;
    always @*
    begin
        tick = 1'b0;
        if (!my_src[3])
        begin
            case ({ctrl_q[`CTRL_LSRC_HI], ctrl_q[`CTRL_LSRC_LO]}) // see R9
                `LSRC_FAST:  tick = fast_t;
                `LSRC_DIV8:  tick = div8_t;
                `LSRC_DIV32: tick = div32_t;
                default:     tick = sub_clock_32k_tick_i;
            endcase
        end
        else
        begin
            // prohibited codes give no tick at all
            case (my_src[2:0]) // see R10
                `SRC_FAST:  tick = fast_t;
                `SRC_DIV8:  tick = div8_t;
                `SRC_DIV32: tick = div32_t;
                `SRC_DIV64: tick = div64_t;
                `SRC_SLOW:  tick = slow_osc_tick_i;
                `SRC_SUB:   tick = sub_clock_32k_tick_i;
                default:    tick = 1'b0;
            endcase
        end
    end

    wire [1:0] gate_mode = {ctrl_q[`CTRL_GATE_HI], ctrl_q[`CTRL_GATE_LO]};
    reg  gate_ok;
    always @*
    begin
        case (gate_mode) // see R7
            `GATE_LOW:  gate_ok = ~gate_lvl_q;
            `GATE_HIGH: gate_ok = gate_lvl_q; // see R2
            default:    gate_ok = 1'b1;
        endcase
    end

    // counter only moves on a tick while running and gated in
    wire run   = ctrl_q[`CTRL_START] & gate_ok; // see R1
    wire step  = run & tick;
    wire under = step & (count_q == {CNT_W{1'b0}});

    // free-running divider; all divided ticks share one phase
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pre_q <= 6'h00;
        end
        else if (enable_i)
        begin
            pre_q <= pre_q + 6'h01;
        end
    end

    // pin is asynchronous: three flops before any decision
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            gate_sync_q <= 3'h0;
        end
        else if (enable_i)
        begin
            gate_sync_q <= {gate_sync_q[1:0], gate_input_pin_i};
        end
    end

    // level accepted once stages two and three agree, on a tick
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            gate_lvl_q <= 1'b0;
        end
        else if (enable_i && tick &&
                 (gate_sync_q[2] == gate_sync_q[1])) // see R15
        begin
            gate_lvl_q <= gate_sync_q[2];
        end
    end

    // ack alternates so each request sees exactly one wait state
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ack_q <= 1'b0;
        end
        else if (enable_i)
        begin
            ack_q <= access & ~ack_q;
        end
    end

    // source select for timers 0 and 1
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            src01_q <= `SRC_RESET;
        end
        else if (wr_en && address_i == `REG_SRC01)
        begin
            src01_q <= writedata_i[7:0];
        end
    end

    // source select for timers 2 and 3
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            src23_q <= `SRC_RESET;
        end
        else if (wr_en && address_i == `REG_SRC23)
        begin
            src23_q <= writedata_i[7:0];
        end
    end

    // timer 4 only: upper nibble has no storage
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            src4_q <= 4'h0;
        end
        else if (wr_en && address_i == `REG_SRC4)
        begin
            src4_q <= writedata_i[3:0];
        end
    end

    // control: start, gate mode, pulse, prescale, legacy source
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            ctrl_q <= `CTRL_RESET;
        end
        else if (wr_en && address_i == `REG_CTRL)
        begin
            ctrl_q <= writedata_i[`CTRL_W-1:0]; // see R5
        end
    end

    // reload value, taken by the counter at underflow
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            reload_q <= {CNT_W{1'b1}};
        end
        else if (wr_en && address_i == `REG_RELOAD)
        begin
            reload_q <= writedata_i[CNT_W-1:0];
        end
    end

    // software write wins over a step in the same cycle
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            count_q <= {CNT_W{1'b1}};
        end
        else if (wr_en && address_i == `REG_COUNT)
        begin
            count_q <= writedata_i[CNT_W-1:0];
        end
        else if (enable_i && under)
        begin
            count_q <= reload_q; // see R3
        end
        else if (enable_i && step)
        begin
            count_q <= count_q - {{(CNT_W-1){1'b0}}, 1'b1}; // see R1
        end
        // stopped or gated out: counter simply holds, see R5
    end

    // pulse level flips on every underflow
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            toggle_q <= 1'b0;
        end
        else if (enable_i && under)
        begin
            toggle_q <= ~toggle_q;
        end
    end

    // set wins over write-one-to-clear
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            status_q <= 1'b0;
        end
        else if (enable_i && under)
        begin
            status_q <= 1'b1; // see R4
        end
        else if (wr_en && address_i == `REG_STATUS && writedata_i[0])
        begin
            status_q <= 1'b0;
        end
    end

    // interrupt mask, one bit
    always @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            mask_q <= 1'b0;
        end
        else if (wr_en && address_i == `REG_MASK)
        begin
            mask_q <= writedata_i[0];
        end
    end

    always @*
    begin
        readdata_o = 32'h0000_0000;
        if (address_i == `REG_SRC01)
            readdata_o[7:0] = src01_q;
        else if (address_i == `REG_SRC23)
            readdata_o[7:0] = src23_q;
        else if (address_i == `REG_SRC4)
            readdata_o[3:0] = src4_q; // see R14
        else if (address_i == `REG_CTRL)
            readdata_o[`CTRL_W-1:0] = ctrl_q;
        else if (address_i == `REG_RELOAD)
            readdata_o[CNT_W-1:0] = reload_q;
        else if (address_i == `REG_COUNT)
            readdata_o[CNT_W-1:0] = count_q;
        else if (address_i == `REG_STATUS)
            readdata_o[0] = status_q;
        else if (address_i == `REG_MASK)
            readdata_o[0] = mask_q;
    end

    // pulse toggles per underflow; inversion flips it
    assign pulse_o = ctrl_q[`CTRL_PULSE_EN] &
                     (toggle_q ^ ctrl_q[`CTRL_PULSE_INV]); // see R8
    assign irq_o   = status_q & mask_q;

endmodule // gated_reload_down_timer

//--- verif/gated_reload_down_timer_properties.sv
`timescale 1ns/10ps
module timer_checker (
    // watched ports
    input wire        clock_i,
    input wire        resetn_i,
    input wire        enable_i,
    input wire [3:0]  address_i,
    input wire        read_i,
    input wire        write_i,
    input wire [31:0] writedata_i,
    input wire [31:0] readdata_o,
    input wire        waitrequest_o,
    input wire        pulse_o,
    input wire        irq_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!resetn_i);
    wire acc;
    assign acc = (read_i | write_i) & !waitrequest_o & enable_i;
    property p_wait; $rose(read_i | write_i) |-> waitrequest_o; endproperty
    a_wait: assert property (p_wait) else $error("no wait state");
    property p_ack;
        (read_i | write_i) && waitrequest_o && enable_i ##1 enable_i
            |-> !waitrequest_o;
    endproperty
    a_ack: assert property (p_ack) else $error("wait too long");
    property p_idle; !(read_i | write_i) |-> !waitrequest_o; endproperty
    a_idle: assert property (p_idle) else $error("wait while idle");
    property p_src4;
        acc && read_i && address_i == 4'h2 |-> readdata_o[31:4] == 28'h0;
    endproperty
    a_src4: assert property (p_src4) else $error("src4 high bits");
    property p_mask;
        acc && write_i && address_i == 4'h7 && !writedata_i[0] |=> !irq_o;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq high");
    property p_sticky; irq_o && !write_i |=> irq_o; endproperty
    a_sticky: assert property (p_sticky) else $error("irq dropped");
    property p_pulse;
        acc && write_i && address_i == 4'h3 && !writedata_i[3] |=> !pulse_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse not off");
    property p_freeze; !enable_i |=> $stable(irq_o) && $stable(pulse_o);
    endproperty
    a_freeze: assert property (p_freeze) else $error("moved while off");
endmodule // timer_checker
bind gated_reload_down_timer timer_checker u_chk (.clock_i, .resetn_i,
    .enable_i, .address_i, .read_i, .write_i, .writedata_i, .readdata_o,
    .waitrequest_o, .pulse_o, .irq_o);

//--- verif/gate_source.sv
`timescale 1ns/10ps
module gate_source #(
    parameter MIN_HOLD = 8
) (
    // clock and requested level
    input  wire clock_i,
    input  wire level_i,
    // gate pin
    output reg  gate_o
);
    reg [7:0] held_q = 8'h00;
    initial gate_o = 1'b0;
    // a new level waits until the old one was held long enough
    always @(posedge clock_i)
    begin
        if (level_i != gate_o && held_q >= MIN_HOLD)
        begin
            gate_o <= level_i;
            held_q <= 8'h00;
        end
        else if (held_q != 8'hff)
            held_q <= held_q + 8'h01;
    end
endmodule // gate_source

//--- verif/gated_reload_down_timer_tb.sv
`timescale 1ns/10ps
module gated_reload_down_timer_tb;
    reg         clock_i = 1'b0;
    reg         resetn_i = 1'b0;
    reg         enable_i = 1'b1;
    reg  [3:0]  address_i = 4'h0;
    reg         read_i = 1'b0;
    reg         write_i = 1'b0;
    reg  [31:0] writedata_i = 32'h0;
    reg         slow_q = 1'b0;
    reg         sub_q = 1'b0;
    reg         level_q = 1'b0;
    wire [31:0] readdata_o;
    wire        waitrequest_o, pulse_o, irq_o, gate_w;
    integer     error_cnt = 0, cmp_count = 0, cyc = 0, tcap, t0, i, e, d;
    reg  [31:0] rdata, c0;
    reg         p0;
    // ctrl, source field and divisor per mode; divisor 0 = no ticks
    localparam [103:0] CT = 104'h21_01_61_a1_e1_21_21_21_21_21_21_21_21;
    localparam [103:0] ST = 104'h00_00_00_00_00_09_0b_0d_0e_08_0a_04_07;
    localparam [103:0] DT = 104'h01_02_08_20_08_08_40_04_08_01_20_01_01;
    always #2.5 clock_i = ~clock_i;
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        slow_q <= (cyc % 4 == 3);
        sub_q <= (cyc % 8 == 7);
    end
    gated_reload_down_timer dut (.clock_i(clock_i), .resetn_i(resetn_i),
        .enable_i(enable_i), .address_i(address_i), .read_i(read_i),
        .write_i(write_i), .writedata_i(writedata_i),
        .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
        .slow_osc_tick_i(slow_q), .sub_clock_32k_tick_i(sub_q),
        .gate_input_pin_i(gate_w), .pulse_o(pulse_o), .irq_o(irq_o));
    gate_source u_gate (.clock_i(clock_i), .level_i(level_q), .gate_o(gate_w));
    task end_sim;
    begin
        $display("checks %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
    endtask
    task chk(input [63:0] nm, input [31:0] exp, input [31:0] got);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            $display("Error %0s exp %h got %h", nm, exp, got);
            error_cnt = error_cnt + 1;
        end
    end
    endtask
    // request held until the rising edge that samples waitrequest low
    task acc(input wr, input [3:0] a, input [31:0] dat);
    begin
        @(posedge clock_i);
        address_i <= a;
        writedata_i <= dat;
        read_i <= !wr;
        write_i <= wr;
        @(posedge clock_i);
        while (waitrequest_o)
            @(posedge clock_i);
        rdata = readdata_o;
        tcap = cyc;
        read_i <= 1'b0;
        write_i <= 1'b0;
    end
    endtask
    task pair(input [63:0] nm, input mv);
    begin
        acc(0, 4'h5, 0);
        c0 = rdata;
        repeat (20) @(posedge clock_i);
        acc(0, 4'h5, 0);
        chk(nm, mv, c0 != rdata);
    end
    endtask
    initial
    begin
        #100000;
        error_cnt = error_cnt + 1;
        end_sim;
    end
    initial
    begin
        repeat (4) @(posedge clock_i);
        resetn_i <= 1'b1;
        acc(0, 4'h5, 0); chk("count", 32'hffff, rdata);
        acc(0, 4'h3, 0); chk("ctrl", 32'h0, rdata);
        acc(1, 4'h9, 32'hffffffff);
        acc(0, 4'h9, 0); chk("hole", 32'h0, rdata);
        acc(1, 4'h2, 32'hff);
        acc(0, 4'h2, 0); chk("src4", 32'hf, rdata);
        acc(1, 4'h1, 32'h5a);
        acc(0, 4'h1, 0); chk("src23", 32'h5a, rdata);
        for (i = 0; i < 13; i = i + 1)
        begin
            acc(1, 4'h3, 0);
            acc(1, 4'h0, ST[i*8+:8]);
            acc(1, 4'h5, 32'h8000);
            acc(1, 4'h3, CT[i*8+:8]);
            acc(0, 4'h5, 0);
            c0 = rdata;
            t0 = tcap;
            repeat (130) @(posedge clock_i);
            acc(0, 4'h5, 0);
            d = c0 - rdata;
            e = DT[i*8+:8] ? (tcap - t0) / DT[i*8+:8] : 0;
            chk("rate", e, d - (d == e + 1));
        end
        acc(1, 4'h0, 0);
        acc(1, 4'h3, 32'h25);
        pair("gatelo", 0);
        level_q <= 1'b1;
        repeat (12) @(posedge clock_i);
        pair("gatehi", 1);
        acc(1, 4'h3, 32'h23);
        pair("lomode", 0);
        acc(1, 4'h3, 32'h27);
        pair("offmode", 1);
        acc(1, 4'h3, 32'h20);
        pair("stop", 0);
        acc(1, 4'h4, 32'h3);
        acc(1, 4'h5, 32'h0);
        acc(1, 4'h6, 32'h1);
        acc(1, 4'h7, 32'h1);
        @(negedge clock_i) chk("irq0", 0, irq_o);
        acc(1, 4'h3, 32'h21);
        enable_i <= 1'b0;
        repeat (5) @(posedge clock_i);
        enable_i <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
        begin
            acc(0, 4'h5, 0); chk("reload", 1, rdata <= 3);
        end
        @(negedge clock_i) chk("irq", 1, irq_o);
        acc(1, 4'h7, 0);
        @(negedge clock_i) chk("masked", 0, irq_o);
        acc(1, 4'h3, 0);
        acc(1, 4'h7, 1);
        @(negedge clock_i) chk("unmask", 1, irq_o);
        acc(1, 4'h6, 1);
        @(negedge clock_i) chk("clear", 0, irq_o);
        acc(1, 4'h3, 32'h08);
        @(negedge clock_i) p0 = pulse_o;
        acc(1, 4'h3, 32'h18);
        @(negedge clock_i) chk("pulse", !p0, pulse_o);
        end_sim;
    end
endmodule // gated_reload_down_timer_tb
